// File: eeprom_host.sv
// eeprom_host.sv: host controller for a 32K x 8 parallel eeprom
// assumes pins go straight to the device; dq is resolved outside from o_dq_oe
`timescale 1ns/1ns
`include "eeprom_host_map.svh"
module eeprom_host #(
    parameter int PAGE_BYTES  = `PAGE_BYTES,
    parameter int GAP_CYC     = `GAP_CYC,
    parameter int SETTLE_CYC  = `SETTLE_CYC,
    parameter int LOCKOUT_CYC = `LOCKOUT_CYC,
    parameter int PROGRAM_CYC = `PROGRAM_CYC
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_sys_rst,
    input  wire logic                        i_req,
    input  wire eeprom_host_pkg::op_t        i_op,
    input  wire logic                        i_protect,
    input  wire logic [14:0]                 i_addr,
    input  wire logic [$clog2(PAGE_BYTES):0] i_count,
    input  wire logic [PAGE_BYTES*8-1:0]     i_page_data,
    output logic                             o_ready,
    output logic                             o_done,
    output logic                             o_timeout,
    output logic [7:0]                       o_rdata,
    output logic [14:0]                      o_mem_addr,
    output logic                             o_mem_ce_n,
    output logic                             o_mem_oe_n,
    output logic                             o_mem_we_n,
    output logic [7:0]                       o_mem_dq,
    output logic                             o_mem_dq_oe,
    input  wire logic [7:0]                  i_mem_dq
);
    localparam int IW = $clog2(PAGE_BYTES);

    initial begin
        if (PAGE_BYTES < 2 || PAGE_BYTES > 64 || (1 << IW) != PAGE_BYTES)
            $error("eeprom_host: PAGE_BYTES must be a power of two from 2 to 64");
        if (GAP_CYC < 1 || GAP_CYC >= SETTLE_CYC || LOCKOUT_CYC < 1 || PROGRAM_CYC < 1 ||
            LOCKOUT_CYC > 2**24 - 1 || PROGRAM_CYC > 2**24 - 1)
            $error("eeprom_host: bad timing parameter");
    end

    // ****************************************
    // command words of the protection prefixes
    // ****************************************
    function automatic logic [22:0] cmd_word(input logic [2:0] idx, input logic disarm);
        case (idx)
            3'h0: cmd_word = {`CMD_ADDR_A, `CMD_DATA_1};
            3'h1: cmd_word = {`CMD_ADDR_B, `CMD_DATA_2};
            3'h2: cmd_word = {`CMD_ADDR_A, disarm ? `CMD_ERASE : `CMD_ARM};
            3'h3: cmd_word = {`CMD_ADDR_A, `CMD_DATA_1};
            3'h4: cmd_word = {`CMD_ADDR_B, `CMD_DATA_2};
            default: cmd_word = {`CMD_ADDR_A, `CMD_DISARM};
        endcase
    endfunction

    // ****************************************
    // pin input synchroniser
    // ****************************************
    logic [7:0] dq_meta_r;
    logic [7:0] dq_sync_r;
    always_ff @(posedge i_clk) begin
        dq_meta_r <= i_mem_dq;
        dq_sync_r <= dq_meta_r;
    end

    typedef enum logic [2:0] {
        H_LOCK,
        H_IDLE,
        H_CMD,
        H_LOAD,
        H_SETTLE,
        H_POLL,
        H_READ
    } hst_t;

    typedef struct packed {
        hst_t        st;
        logic [23:0] tmr;
        logic [2:0]  cidx;
        logic [2:0]  clen;
        logic        disarm;
        logic [IW:0] bidx;
        logic [IW:0] bcnt;
        logic [14:0] addr;
        logic [7:0]  dq;
        logic        go;
        logic        gowr;
        logic        waitcyc;
        logic [7:0]  last;
        logic        done;
        logic        tout;
    } host_t;

    host_t s_r;
    host_t s_nxt;
    logic        cyc_busy;
    logic        cyc_done;
    logic [7:0]  cyc_rdata;
    logic [7:0]  pick;

    always_comb pick = i_page_data[8*s_r.bidx[IW-1:0] +: 8];

    always_comb begin
        s_nxt = s_r;
        s_nxt.go = 1'b0;
        s_nxt.done = 1'b0;
        if (s_r.tmr != 24'h0)
            s_nxt.tmr = s_r.tmr - 24'h1;
        case (s_r.st)
            H_LOCK: begin
                // device refuses writes for up to the full lockout after power-up
                if (s_r.tmr == 24'h0)
                    s_nxt.st = H_IDLE;
            end
            H_IDLE: begin
                if (i_req) begin
                    s_nxt.tout = 1'b0;
                    s_nxt.tmr = 24'h0;                                        // stale poll time would stall strobes
                    s_nxt.addr = i_addr;
                    s_nxt.bidx = '0;
                    s_nxt.bcnt = (i_count == '0) ? (IW+1)'(1) : i_count;
                    s_nxt.cidx = 3'h0;
                    s_nxt.disarm = (i_op == eeprom_host_pkg::OP_DISARM);
                    s_nxt.waitcyc = 1'b0;
                    case (i_op)
                        eeprom_host_pkg::OP_READ: begin
                            s_nxt.st = H_READ;
                            s_nxt.go = 1'b1;
                            s_nxt.gowr = 1'b0;
                        end
                        eeprom_host_pkg::OP_ARM: begin
                            s_nxt.st = H_CMD;
                            s_nxt.clen = 3'h3;
                            s_nxt.bcnt = '0;
                        end
                        eeprom_host_pkg::OP_DISARM: begin
                            s_nxt.st = H_CMD;
                            s_nxt.clen = 3'h6;
                            s_nxt.bcnt = '0;
                        end
                        default: begin
                            s_nxt.st = i_protect ? H_CMD : H_LOAD;
                            s_nxt.clen = 3'h3;
                        end
                    endcase
                end
            end
            H_CMD, H_LOAD: begin
                // one strobe per step; gap kept inside the device's load timer
                if (!s_r.waitcyc && !cyc_busy && !s_r.go && s_r.tmr == 24'h0) begin
                    s_nxt.go = 1'b1;
                    s_nxt.gowr = 1'b1;
                    s_nxt.waitcyc = 1'b1;
                    if (s_r.st == H_CMD)
                        {s_nxt.addr, s_nxt.dq} = cmd_word(s_r.cidx, s_r.disarm);
                    else begin
                        s_nxt.addr = {i_addr[14:IW], s_r.bidx[IW-1:0]};
                        s_nxt.dq = pick;
                        s_nxt.last = pick;
                    end
                end else if (s_r.waitcyc && cyc_done) begin
                    s_nxt.waitcyc = 1'b0;
                    s_nxt.tmr = 24'(GAP_CYC);
                    if (s_r.st == H_CMD) begin
                        s_nxt.cidx = s_r.cidx + 3'h1;
                        if (s_r.cidx + 3'h1 == s_r.clen) begin
                            s_nxt.st = (s_r.bcnt == '0) ? H_SETTLE : H_LOAD;
                            s_nxt.tmr = (s_r.bcnt == '0) ? 24'(SETTLE_CYC) : 24'(GAP_CYC);
                        end
                    end else begin
                        s_nxt.bidx = s_r.bidx + (IW+1)'(1);
                        if (s_r.bidx + (IW+1)'(1) == s_r.bcnt) begin
                            s_nxt.st = H_SETTLE;
                            s_nxt.tmr = 24'(SETTLE_CYC);
                        end
                    end
                end
            end
            H_SETTLE: begin
                if (s_r.tmr == 24'h0) begin
                    if (s_r.bcnt == '0) begin
                        s_nxt.st = H_IDLE;
                        s_nxt.done = 1'b1;
                    end else begin
                        s_nxt.st = H_POLL;
                        s_nxt.tmr = 24'(PROGRAM_CYC);
                        s_nxt.go = 1'b1;
                        s_nxt.gowr = 1'b0;
                    end
                end
            end
            H_POLL: begin
                // poll the last loaded byte; true top bit means programming ended
                if (cyc_done) begin
                    if (cyc_rdata[7] == s_r.last[7]) begin
                        s_nxt.st = H_IDLE;
                        s_nxt.done = 1'b1;
                    end else if (s_r.tmr == 24'h0) begin
                        s_nxt.st = H_IDLE;
                        s_nxt.done = 1'b1;
                        s_nxt.tout = 1'b1;
                    end else
                        s_nxt.go = 1'b1;
                end
            end
            H_READ: begin
                if (cyc_done) begin
                    s_nxt.st = H_IDLE;
                    s_nxt.done = 1'b1;
                end
            end
            default: s_nxt.st = H_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst) begin
            s_r <= '0;
            s_r.st <= H_LOCK;
            s_r.tmr <= 24'(LOCKOUT_CYC);
        end else
            s_r <= s_nxt;
    end

    eeprom_host_cycle u_cycle (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_start   (s_r.go),
        .i_write   (s_r.gowr),
        .i_dq_sync (dq_sync_r),
        .o_ce_n    (o_mem_ce_n),
        .o_oe_n    (o_mem_oe_n),
        .o_we_n    (o_mem_we_n),
        .o_dq_oe   (o_mem_dq_oe),
        .o_busy    (cyc_busy),
        .o_done    (cyc_done),
        .o_rdata   (cyc_rdata)
    );

    // address and data held in flops for the whole strobe
    assign o_mem_addr = s_r.addr;
    assign o_mem_dq   = s_r.dq;
    assign o_ready    = (s_r.st == H_IDLE);
    assign o_done     = s_r.done;
    assign o_timeout  = s_r.tout;
    assign o_rdata    = cyc_rdata;

    property p_lockout;
        @(posedge i_clk) disable iff (i_sys_rst) $past(s_r.st) == H_LOCK && $past(s_r.tmr) != 24'h0 |-> o_mem_we_n;
    endproperty
    a_lockout: assert property (p_lockout) else $error("write during power-up lockout");
    property p_gap;
        @(posedge i_clk) disable iff (i_sys_rst) s_r.st == H_CMD || s_r.st == H_LOAD |-> s_r.tmr <= 24'(GAP_CYC);
    endproperty
    a_gap: assert property (p_gap) else $error("load gap longer than the safe window");
    property p_settle;
        @(posedge i_clk) disable iff (i_sys_rst) s_r.st == H_SETTLE |-> o_mem_we_n && o_mem_ce_n;
    endproperty
    a_settle: assert property (p_settle) else $error("strobe during settle");
endmodule // eeprom_host

// File: eeprom_host_map.svh
// eeprom_host_map.svh: offsets, codes and timing counts for the parallel eeprom host
// assumes a 50 MHz system clock; included by the host modules only
`ifndef EEPROM_HOST_MAP_SVH
`define EEPROM_HOST_MAP_SVH

`define CLK_PERIOD_NS        20
// byte_load_window upper bound, microseconds
`define BYTE_LOAD_WINDOW_US  100
// strobes are held well over the 20 ns glitch floor and 100 ns pulse width
`define WRITE_PULSE_WIDTH_NS 160
`define READ_ACCESS_NS       300
// power_up_write_lockout maximum and program cycle maximum, milliseconds
`define POWER_UP_LOCKOUT_MS  10
`define PROGRAM_CYCLE_MS     10

`define PULSE_CYC   ((`WRITE_PULSE_WIDTH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ACCESS_CYC  ((`READ_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// half the window: safely inside the device's byte load timer
`define GAP_CYC     ((`BYTE_LOAD_WINDOW_US * 1000 / `CLK_PERIOD_NS) / 2)
// after the last load the strobe must stay high past the full window
`define SETTLE_CYC  ((`BYTE_LOAD_WINDOW_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + 2)
`define LOCKOUT_CYC ((`POWER_UP_LOCKOUT_MS * 1000000) / `CLK_PERIOD_NS)
`define PROGRAM_CYC ((`PROGRAM_CYCLE_MS * 1000000) / `CLK_PERIOD_NS)

// command prefix addresses and data
`define CMD_ADDR_A   15'h5555
`define CMD_ADDR_B   15'h2aaa
`define CMD_DATA_1   8'haa
`define CMD_DATA_2   8'h55
`define CMD_ARM      8'ha0
`define CMD_ERASE    8'h80
`define CMD_DISARM   8'h20

`define PAGE_BYTES   64
`endif

// File: eeprom_host_pkg.sv
// eeprom_host_pkg.sv: types shared by the eeprom host modules
// assumes nothing beyond a SystemVerilog compiler
package eeprom_host_pkg;
    typedef enum logic [1:0] {
        OP_READ,
        OP_WRITE,
        OP_ARM,
        OP_DISARM
    } op_t;
endpackage

// File: eeprom_host_cycle.sv
// eeprom_host_cycle.sv: one read or one write strobe on the eeprom pins
// assumes the caller holds address and data stable until o_done
`timescale 1ns/1ns
`include "eeprom_host_map.svh"
module eeprom_host_cycle #(
    parameter int PULSE_CYC  = `PULSE_CYC,
    parameter int ACCESS_CYC = `ACCESS_CYC
) (
    input  wire logic        i_clk,
    input  wire logic        i_sys_rst,
    input  wire logic        i_start,
    input  wire logic        i_write,
    input  wire logic [7:0]  i_dq_sync,
    output logic             o_ce_n,
    output logic             o_oe_n,
    output logic             o_we_n,
    output logic             o_dq_oe,
    output logic             o_busy,
    output logic             o_done,
    output logic [7:0]       o_rdata
);
    initial begin
        if (PULSE_CYC < 2 || ACCESS_CYC < 3 || PULSE_CYC > 255 || ACCESS_CYC > 255)
            $error("eeprom_host_cycle: bad timing parameter");
    end

    typedef enum logic [1:0] {
        C_IDLE,
        C_WSTROBE,
        C_RSTROBE,
        C_RECOVER
    } cst_t;

    typedef struct packed {
        cst_t       st;
        logic [7:0] cnt;
        logic       wr;
        logic [7:0] rdata;
        logic       done;
    } cyc_t;

    cyc_t s_r;
    cyc_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        case (s_r.st)
            C_IDLE: begin
                if (i_start) begin
                    s_nxt.st = i_write ? C_WSTROBE : C_RSTROBE;
                    s_nxt.wr = i_write;
                    s_nxt.cnt = i_write ? 8'(PULSE_CYC) : 8'(ACCESS_CYC);
                end
            end
            C_WSTROBE: begin
                if (s_r.cnt == 8'h01)
                    s_nxt.st = C_RECOVER;
                s_nxt.cnt = s_r.cnt - 8'h01;
            end
            C_RSTROBE: begin
                // data has passed both sync stages before it is taken
                if (s_r.cnt == 8'h01) begin
                    s_nxt.rdata = i_dq_sync;
                    s_nxt.st = C_RECOVER;
                end
                s_nxt.cnt = s_r.cnt - 8'h01;
            end
            C_RECOVER: begin
                s_nxt.st = C_IDLE;
                s_nxt.done = 1'b1;
            end
            default: s_nxt.st = C_IDLE;
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (i_sys_rst)
            s_r <= '{st: C_IDLE, cnt: 8'h00, wr: 1'b0, rdata: 8'h00, done: 1'b0};
        else
            s_r <= s_nxt;
    end

    // write: ce and we low with oe high; oe held high keeps the device off the bus
    assign o_we_n  = ~(s_r.st == C_WSTROBE);
    assign o_oe_n  = ~(s_r.st == C_RSTROBE);
    assign o_ce_n  = ~(s_r.st == C_WSTROBE || s_r.st == C_RSTROBE);
    // data stays driven one cycle past the rising strobe for hold time
    assign o_dq_oe = (s_r.st == C_WSTROBE) || (s_r.st == C_RECOVER && s_r.wr);
    assign o_busy  = (s_r.st != C_IDLE);
    assign o_done  = s_r.done;
    assign o_rdata = s_r.rdata;

    property p_pulse_len;
        @(posedge i_clk) disable iff (i_sys_rst) $fell(o_we_n) |-> !o_we_n [*2];
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("write strobe shorter than two cycles");
    property p_no_fight;
        @(posedge i_clk) disable iff (i_sys_rst) !o_oe_n |-> !o_dq_oe && o_we_n;
    endproperty
    a_no_fight: assert property (p_no_fight) else $error("host drives data during a read");
    property p_write_qual;
        @(posedge i_clk) disable iff (i_sys_rst) !o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe;
    endproperty
    a_write_qual: assert property (p_write_qual) else $error("write strobe without select or data");
endmodule // eeprom_host_cycle

// File: eeprom_model.sv
// eeprom_model.sv: behavioural 32K x 8 parallel eeprom answering the host pins
// assumes pins are sampled on the falling system clock edge; dq is resolved outside
`timescale 1ns/1ns
module eeprom_model #(
    parameter int LOAD_CYC = 20,
    parameter int PROG_CYC = 200,
    parameter int LOCK_CYC = 10
) (
    input  wire logic        i_clk,
    input  wire logic        i_pwr_rst,
    input  wire logic [14:0] i_addr,
    input  wire logic        i_ce_n,
    input  wire logic        i_oe_n,
    input  wire logic        i_we_n,
    input  wire logic [7:0]  i_dq,
    output logic [7:0]       o_dq,
    output logic             o_dq_en
);
    // ********************************
    // array, load buffer, status
    // ********************************
    logic [7:0]  mem [0:32767];
    logic [14:0] ba  [0:69];
    logic [7:0]  bd  [0:69];
    logic [14:0] la_r;
    logic [7:0]  last_r;
    logic [7:0]  held_r = 8'h00;
    logic        act_r;
    logic        rd_r;
    logic        tog_r;
    logic        prot_r;
    int          nb;
    int          tmr;
    int          busy;
    int          lock;
    int          k0;
    wire         act = ~i_we_n & ~i_ce_n & i_oe_n;
    wire         rd  = ~i_ce_n & ~i_oe_n & i_we_n;

    // protection is only initialised here, never on i_pwr_rst, so it survives every power cycle
    initial begin
        prot_r = 1'b0;
        for (int i = 0; i < 32768; i++) mem[i] = 8'hff;
    end

    function automatic logic hit(int i, logic [14:0] a, logic [7:0] d);
        return ba[i] === a && bd[i] === d;
    endfunction

    task automatic commit();
        k0 = 0;
        if (nb >= 6 && hit(0, 15'h5555, 8'haa) && hit(1, 15'h2aaa, 8'h55) && hit(2, 15'h5555, 8'h80)
            && hit(3, 15'h5555, 8'haa) && hit(4, 15'h2aaa, 8'h55) && hit(5, 15'h5555, 8'h20)) begin
            prot_r = 1'b0;
            k0 = 6;
        end else if (nb >= 3 && hit(0, 15'h5555, 8'haa) && hit(1, 15'h2aaa, 8'h55)
            && hit(2, 15'h5555, 8'ha0)) begin
            prot_r = 1'b1;
            k0 = 3;
        end else if (prot_r) begin
            k0 = nb;
        end
        for (int i = k0; i < nb; i++) begin
            mem[{ba[nb-1][14:6], ba[i][5:0]}] = bd[i];
            last_r = bd[i];
            busy = PROG_CYC;
        end
        nb = 0;
    endtask

    // sampling once a cycle drops strobe pulses shorter than a period
    always @(negedge i_clk) begin
        if (i_pwr_rst) begin
            lock = LOCK_CYC;
            nb = 0;
            busy = 0;
            tmr = 0;
            tog_r = 1'b0;
            act_r = 1'b0;
            rd_r = 1'b0;
        end else begin
            if (lock > 0) lock--;
            if (busy > 0) busy--;
            if (rd && !rd_r && busy > 0) tog_r = ~tog_r;
            if (act && !act_r) la_r = i_addr;
            if (act_r && !act && lock == 0 && busy == 0 && nb < 70) begin
                ba[nb] = la_r;
                bd[nb] = i_dq;
                nb++;
                tmr = 0;
            end else if (nb > 0 && !act) begin
                tmr++;
                if (tmr >= LOAD_CYC) commit();
            end
            if (rd) held_r = o_dq;
            act_r = act;
            rd_r = rd;
        end
    end

    // a released bus shows the inverse of the last driven byte
    always_comb begin
        o_dq_en = rd;
        if (!rd) o_dq = ~held_r;
        else if (busy > 0) o_dq = {~last_r[7], tog_r, 6'h2a};
        else o_dq = mem[i_addr];
    end
endmodule // eeprom_model

// File: parallel_eeprom_access_protect_test.sv
// parallel_eeprom_access_protect_test.sv: self-checking bench for the eeprom host
// assumes eeprom_model on the pins and shortened lockout, gap, settle and poll counts
`timescale 1ns/1ns
module parallel_eeprom_access_protect_test;
    typedef struct packed {
        logic [1:0]  op;
        logic        prot;
        logic [14:0] addr;
        logic [6:0]  cnt;
        logic [7:0]  base;
        logic [7:0]  exp;
    } row_t;
    logic                 i_clk       = 1'b0;
    logic                 i_sys_rst   = 1'b1;
    logic                 i_req       = 1'b0;
    eeprom_host_pkg::op_t i_op        = eeprom_host_pkg::OP_READ;
    logic                 i_protect   = 1'b0;
    logic [14:0]          i_addr      = 15'h0000;
    logic [6:0]           i_count     = 7'h01;
    logic [511:0]         i_page_data = '0;
    logic                 o_ready;
    logic                 o_done;
    logic                 o_timeout;
    logic [7:0]           o_rdata;
    logic [14:0]          o_mem_addr;
    logic                 o_mem_ce_n;
    logic                 o_mem_oe_n;
    logic                 o_mem_we_n;
    logic [7:0]           o_mem_dq;
    logic                 o_mem_dq_oe;
    wire  [7:0]           mdl_dq;
    wire                  mdl_en;
    wire  [7:0]           dq_bus = o_mem_dq_oe ? o_mem_dq : mdl_dq;
    int                   n_mismatch  = 0;
    int                   checked     = 0;

    // ********************************
    // ordinary cases: write rows check the poll timeout, read rows the data
    // ********************************
    localparam row_t ROWS [13] = '{
        '{2'h1, 1'b0, 15'h0040, 7'h01, 8'h3c, 8'h00},
        '{2'h0, 1'b0, 15'h0040, 7'h01, 8'h00, 8'h3c},
        '{2'h1, 1'b0, 15'h0080, 7'h40, 8'h10, 8'h00},
        '{2'h0, 1'b0, 15'h0080, 7'h01, 8'h00, 8'h10},
        '{2'h0, 1'b0, 15'h00bf, 7'h01, 8'h00, 8'h4f},
        '{2'h1, 1'b0, 15'h0100, 7'h03, 8'ha0, 8'h00},
        '{2'h0, 1'b0, 15'h0102, 7'h01, 8'h00, 8'ha2},
        '{2'h0, 1'b0, 15'h0103, 7'h01, 8'h00, 8'hff},
        '{2'h2, 1'b0, 15'h0000, 7'h01, 8'h00, 8'h00},
        '{2'h1, 1'b0, 15'h0200, 7'h01, 8'h55, 8'h01},
        '{2'h0, 1'b0, 15'h0200, 7'h01, 8'h00, 8'hff},
        '{2'h1, 1'b1, 15'h0200, 7'h01, 8'h66, 8'h00},
        '{2'h0, 1'b0, 15'h0200, 7'h01, 8'h00, 8'h66}
    };

    eeprom_host #(.LOCKOUT_CYC(20), .PROGRAM_CYC(2000), .GAP_CYC(10), .SETTLE_CYC(30)) DUT (
        .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_req(i_req), .i_op(i_op), .i_protect(i_protect),
        .i_addr(i_addr), .i_count(i_count), .i_page_data(i_page_data), .o_ready(o_ready),
        .o_done(o_done), .o_timeout(o_timeout), .o_rdata(o_rdata), .o_mem_addr(o_mem_addr),
        .o_mem_ce_n(o_mem_ce_n), .o_mem_oe_n(o_mem_oe_n), .o_mem_we_n(o_mem_we_n),
        .o_mem_dq(o_mem_dq), .o_mem_dq_oe(o_mem_dq_oe), .i_mem_dq(dq_bus));

    eeprom_model mem_model (
        .i_clk(i_clk), .i_pwr_rst(i_sys_rst), .i_addr(o_mem_addr), .i_ce_n(o_mem_ce_n),
        .i_oe_n(o_mem_oe_n), .i_we_n(o_mem_we_n), .i_dq(dq_bus), .o_dq(mdl_dq), .o_dq_en(mdl_en));

    initial begin
        forever #10 i_clk = ~i_clk;
    end

    task automatic results();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // entered and left just after a rising edge
    task automatic do_op(row_t r);
        int n;
        i_op = eeprom_host_pkg::op_t'(r.op);
        i_protect = r.prot;
        i_addr = r.addr;
        i_count = r.cnt;
        for (int k = 0; k < 64; k++) i_page_data[8*k +: 8] = r.base + 8'(k);
        i_req = 1'b1;
        n = 0;
        while (o_ready !== 1'b1 && n < 100) begin
            @(posedge i_clk);
            #2;
            n++;
        end
        @(posedge i_clk);
        #2;
        i_req = 1'b0;
        while (o_done !== 1'b1 && n < 20000) begin
            @(posedge i_clk);
            #2;
            n++;
        end
        if (n >= 20000) begin
            n_mismatch++;
            $display("[FAIL] done expected 1 seen 0");
            results();
        end
    endtask

    // host must never drive dq while the device may
    always @(negedge i_clk) begin
        if (!i_sys_rst && o_mem_dq_oe && mdl_en) begin
            n_mismatch++;
            $display("[FAIL] dq contention expected 0 seen 1");
        end
    end

    initial begin
        repeat (20) @(posedge i_clk);
        #2;
        i_sys_rst = 1'b0;
        foreach (ROWS[i]) begin
            do_op(ROWS[i]);
            if (ROWS[i].op == 2'h0) chk("rdata", ROWS[i].exp, o_rdata);
            else chk("timeout", ROWS[i].exp, {7'h00, o_timeout});
        end
        // ********************************
        // second power cycle, lockout, persistence, disarm
        // ********************************
        i_sys_rst = 1'b1;
        repeat (20) begin
            @(posedge i_clk);
            #2;
        end
        chk("reset pins", 8'h13, {3'h0, o_mem_oe_n, o_ready, o_mem_dq_oe, o_mem_we_n, o_mem_ce_n});
        i_sys_rst = 1'b0;
        repeat (18) begin
            @(posedge i_clk);
            #2;
            chk("lockout pins", 8'h13, {3'h0, o_mem_oe_n, o_ready, o_mem_dq_oe, o_mem_we_n, o_mem_ce_n});
        end
        do_op(row_t'{2'h1, 1'b0, 15'h0300, 7'h01, 8'h11, 8'h01});
        chk("timeout", 8'h01, {7'h00, o_timeout});
        do_op(row_t'{2'h3, 1'b0, 15'h0000, 7'h01, 8'h00, 8'h00});
        do_op(row_t'{2'h1, 1'b0, 15'h0300, 7'h01, 8'h77, 8'h00});
        chk("timeout", 8'h00, {7'h00, o_timeout});
        do_op(row_t'{2'h0, 1'b0, 15'h0300, 7'h01, 8'h00, 8'h77});
        chk("rdata", 8'h77, o_rdata);
        results();
    end
endmodule // parallel_eeprom_access_protect_test
